// ==== sfps_defs.svh ====
`ifndef SFPS_DEFS_SVH
`define SFPS_DEFS_SVH
// ---------------------------------------------------------------
// Timing, in microseconds, and the core clock rate
// ---------------------------------------------------------------
`define SFPS_CLK_MHZ 100
`define SFPS_T_PP_US 500
`define SFPS_T_SSE_US 50000
`define SFPS_T_SE_US 200000
`define SFPS_T_BE_US 1000000
`define SFPS_T_SUS_US 30
// ---------------------------------------------------------------
// Opcodes
// ---------------------------------------------------------------
`define SFPS_OP_WREN 8'h06
`define SFPS_OP_WRDI 8'h04
`define SFPS_OP_EN4 8'hb7
`define SFPS_OP_EX4 8'he9
`define SFPS_OP_CLF 8'h50
`define SFPS_OP_PP 8'h02
`define SFPS_OP_QPP 8'h32
`define SFPS_OP_EQPP 8'h38
`define SFPS_OP_PP4 8'h12
`define SFPS_OP_QPP4 8'h34
`define SFPS_OP_EQPP4 8'h3e
`define SFPS_OP_SSE 8'h20
`define SFPS_OP_SSE4 8'h21
`define SFPS_OP_SE 8'hd8
`define SFPS_OP_SE4 8'hdc
`define SFPS_OP_BE 8'hc7
`define SFPS_OP_SUS 8'h75
`define SFPS_OP_RES 8'h7a
// ---------------------------------------------------------------
// Flag status layout, protocol codes, address fields
// ---------------------------------------------------------------
`define SFPS_FSR_RST 8'h80
`define SFPS_FSR_RDY 7
`define SFPS_FSR_ESUS 6
`define SFPS_FSR_EERR 5
`define SFPS_FSR_PERR 4
`define SFPS_FSR_PSUS 2
`define SFPS_FSR_PROT 1
`define SFPS_PR_DUAL 2'h1
`define SFPS_PR_QUAD 2'h2
`define SFPS_LOCK_LO 22
`define SFPS_SECT_LO 16
`define SFPS_BYTE_BITS 4'h8
`endif

// ==== sfps_pkg.sv ====
package sfps_pkg;
  typedef enum {ST_IDLE, ST_RUN, ST_SUSW} sfps_state_t;
  typedef enum logic [1:0] {OP_PP, OP_SSE, OP_SE, OP_BE} sfps_op_t;
endpackage

// ==== sfps_core.sv ====
`timescale 1ns/1ps
`include "sfps_defs.svh"
module sfps_core #(
  parameter int PP_CYC = `SFPS_T_PP_US * `SFPS_CLK_MHZ,
  parameter int SSE_CYC = `SFPS_T_SSE_US * `SFPS_CLK_MHZ,
  parameter int SE_CYC = `SFPS_T_SE_US * `SFPS_CLK_MHZ,
  parameter int BE_CYC = `SFPS_T_BE_US * `SFPS_CLK_MHZ
) (
  input logic CLK,
  input logic RST_B,
  input logic SCK,
  input logic CS_B,
  input logic [3:0] DQ_I,
  input logic [1:0] PROTO,
  input logic NV_ADDR4,
  input logic [15:0] LOCK_MAP,
  input logic OP_FAIL,
  output logic [7:0] FSR,
  output logic SR_WIP,
  output logic SR_WEL,
  output logic ADDR4,
  output logic PB_LOAD,
  output logic [7:0] PB_OFFSET,
  output logic [7:0] PB_DATA,
  output logic ARR_GO,
  output sfps_pkg::sfps_op_t ARR_OP,
  output logic [31:0] ARR_ADDR
);
  import sfps_pkg::*;

  localparam int SUS_CYC = `SFPS_T_SUS_US * `SFPS_CLK_MHZ;

  // ---------------------------------------------------------------
  // Helper functions
  // ---------------------------------------------------------------
  // Address bytes for an opcode
  function automatic logic [8:0] nab_f(input logic [7:0] op, input logic a4);
    if (a4 || op == `SFPS_OP_PP4 || op == `SFPS_OP_QPP4 || op == `SFPS_OP_EQPP4 ||
        op == `SFPS_OP_SSE4 || op == `SFPS_OP_SE4) begin
      nab_f = 9'h4;
    end else begin
      nab_f = 9'h3;
    end
  endfunction

  function automatic logic is_prog_f(input logic [7:0] op);
    is_prog_f = op == `SFPS_OP_PP || op == `SFPS_OP_QPP || op == `SFPS_OP_EQPP ||
                op == `SFPS_OP_PP4 || op == `SFPS_OP_QPP4 || op == `SFPS_OP_EQPP4;
  endfunction

  // Active data lines for the byte at position idx
  function automatic logic [3:0] lanes_f(input logic [1:0] pr, input logic [7:0] op,
                                         input logic [8:0] idx, input logic [8:0] nab);
    logic eq;
    eq = op == `SFPS_OP_EQPP || op == `SFPS_OP_EQPP4;
    if (pr == `SFPS_PR_QUAD) begin
      lanes_f = 4'h4;
    end else if (pr == `SFPS_PR_DUAL) begin
      lanes_f = 4'h2;
    end else if (idx == 9'h0) begin
      lanes_f = 4'h1;
    end else if (idx <= nab) begin
      lanes_f = eq ? 4'h4 : 4'h1;
    end else begin
      lanes_f = (eq || op == `SFPS_OP_QPP || op == `SFPS_OP_QPP4) ? 4'h4 : 4'h1;
    end
  endfunction

  // ---------------------------------------------------------------
  // Reset release and pin synchronisers (core clock)
  // ---------------------------------------------------------------
  logic rs1_q, rst_n, cs1_q, cs2_q, cs3_q, pt1_q, pt2_q, pt3_q, nv1_q, nv2_q;
  logic [15:0] lk1_q, lk2_q;
  // Page-load toggle from the link side, declared here for its synchroniser
  logic pbt_q;
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      rs1_q <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rs1_q <= 1'b1;
      rst_n <= rs1_q;
    end
  end

  // Chip select, page-load toggle, strap and lock map
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      {cs1_q, cs2_q, cs3_q} <= 3'h7;
      {pt1_q, pt2_q, pt3_q} <= 3'h0;
      {nv1_q, nv2_q} <= 2'h0;
      lk1_q <= 16'h0;
      lk2_q <= 16'h0;
    end else begin
      cs1_q <= CS_B;
      cs2_q <= cs1_q;
      cs3_q <= cs2_q;
      pt1_q <= pbt_q;
      pt2_q <= pt1_q;
      pt3_q <= pt2_q;
      nv1_q <= NV_ADDR4;
      nv2_q <= nv1_q;
      lk1_q <= LOCK_MAP;
      lk2_q <= lk1_q;
    end
  end

  // ---------------------------------------------------------------
  // Link side (serial clock)
  // ---------------------------------------------------------------
  // Mode bits cross as static levels; the opcode byte gives them time to settle
  logic a4s1_q, a4s2_q, a4_q;
  logic [1:0] prs1_q, prs2_q;
  logic [3:0] bc_q, ln, bc_d;
  logic [8:0] idx_q, idx_d, lnab, cnt_q;
  logic [7:0] sh_q, sh_d, op_q, off_q, pbd_q, pbo_q;
  logic [31:0] ad_q;
  logic done, ok_q, fr_q;
  always_ff @(posedge SCK or negedge rst_n) begin
    if (!rst_n) begin
      {a4s1_q, a4s2_q} <= 2'h0;
      {prs1_q, prs2_q} <= 4'h0;
    end else begin
      a4s1_q <= a4_q;
      a4s2_q <= a4s1_q;
      prs1_q <= PROTO;
      prs2_q <= prs1_q;
    end
  end

  always_comb begin
    lnab = nab_f(op_q, a4s2_q);
    ln = lanes_f(prs2_q, op_q, idx_q, lnab);
    if (ln == 4'h4) begin
      sh_d = {sh_q[3:0], DQ_I};
    end else if (ln == 4'h2) begin
      sh_d = {sh_q[5:0], DQ_I[1:0]};
    end else begin
      sh_d = {sh_q[6:0], DQ_I[0]};
    end
    done = (bc_q + ln) == `SFPS_BYTE_BITS;
    bc_d = done ? 4'h0 : bc_q + ln;
    idx_d = (done && idx_q != 9'h1ff) ? idx_q + 9'h1 : idx_q;
  end

  // Frame counters; chip select high clears them between frames
  // bytes close after 8/lanes edges
  always_ff @(posedge SCK or posedge CS_B) begin
    if (CS_B) begin
      bc_q <= 4'h0;
      idx_q <= 9'h0;
      sh_q <= 8'h0;
    end else begin
      bc_q <= bc_d;
      idx_q <= idx_d;
      sh_q <= sh_d;
    end
  end

  // Frame results; stable while the serial clock stands, read by the core after CS rises
  // ok_q says the last edge closed a whole byte
  always_ff @(posedge SCK or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= 9'h0;
      ok_q <= 1'b0;
      fr_q <= 1'b0;
    end else begin
      cnt_q <= idx_d;
      ok_q <= done;
      if (idx_q == 9'h0 && bc_q == 4'h0) begin
        fr_q <= ~fr_q;
      end
    end
  end

  // Opcode, address and page-buffer bytes
  always_ff @(posedge SCK or negedge rst_n) begin
    if (!rst_n) begin
      op_q <= 8'h0;
      ad_q <= 32'h0;
      off_q <= 8'h0;
      pbd_q <= 8'h0;
      pbo_q <= 8'h0;
      pbt_q <= 1'b0;
    end else if (done) begin
      if (idx_q == 9'h0) begin
        op_q <= sh_d;
      end else if (idx_q <= lnab) begin
        ad_q <= {ad_q[23:0], sh_d};
        if (idx_q == lnab) begin
          off_q <= sh_d;
        end
      end else if (is_prog_f(op_q)) begin
        // 8-bit offset wraps inside the page
        pbd_q <= sh_d;
        pbo_q <= off_q;
        off_q <= off_q + 8'h1;
        pbt_q <= ~pbt_q;
      end
    end
  end

  // ---------------------------------------------------------------
  // Command decode (core clock)
  // ---------------------------------------------------------------
  sfps_state_t st_q;
  sfps_op_t kind_q, nkind, erk_q;
  logic [31:0] rem_q, lat_q, per_q, eer_q, addr, ndur, erad_q;
  logic [8:0] nab;
  logic [7:0] fsr_q;
  logic frl_q, wel_q, end_ev, go, busy, locked, shit, prg_ok, prg_start, er_try;
  logic er_lock, er_start, start, sus_cmd, res_cmd, res_pg, res_er, fin, sus_done;
  logic pgv_q, erv_q, clf, is_er;

  // only a frame closed on a byte boundary counts
  assign end_ev = cs2_q && !cs3_q && (fr_q != frl_q);
  assign go = end_ev && ok_q;
  assign busy = st_q != ST_IDLE;
  assign nab = nab_f(op_q, a4_q);
  assign addr = (nab == 9'h4) ? ad_q : {8'h00, ad_q[23:0]};
  assign locked = lk2_q[addr[`SFPS_LOCK_LO +: 4]];
  assign shit = erv_q && addr[31:`SFPS_SECT_LO] == erad_q[31:`SFPS_SECT_LO];
  assign clf = go && op_q == `SFPS_OP_CLF;
  assign is_er = op_q == `SFPS_OP_SSE || op_q == `SFPS_OP_SSE4 ||
                 op_q == `SFPS_OP_SE || op_q == `SFPS_OP_SE4;
  // Program needs the latch, an address and one data byte; busy means ignore
  assign prg_ok = go && is_prog_f(op_q) && cnt_q >= nab + 9'h2 && wel_q && !busy && !pgv_q;
  assign prg_start = prg_ok && !locked && !shit;
  // no latch, no erase and no flags
  assign er_try = go && wel_q && !busy && !erv_q && !pgv_q &&
                  ((is_er && cnt_q >= nab + 9'h1) || op_q == `SFPS_OP_BE);
  assign er_lock = er_try && (op_q == `SFPS_OP_BE ? |lk2_q : locked);
  assign er_start = er_try && !er_lock;
  assign start = prg_start || er_start;
  assign sus_cmd = go && op_q == `SFPS_OP_SUS && st_q == ST_RUN && kind_q != OP_BE;
  // resume only acts when idle with something saved
  assign res_cmd = go && op_q == `SFPS_OP_RES && !busy;
  assign res_pg = res_cmd && pgv_q;
  assign res_er = res_cmd && !pgv_q && erv_q;
  assign fin = busy && (rem_q == 32'h1 || OP_FAIL);
  assign sus_done = st_q == ST_SUSW && lat_q == 32'h1 && !fin;

  always_comb begin
    if (prg_start) begin
      nkind = OP_PP;
      ndur = 32'(PP_CYC);
    end else if (op_q == `SFPS_OP_BE) begin
      nkind = OP_BE;
      ndur = 32'(BE_CYC);
    end else if (op_q == `SFPS_OP_SSE || op_q == `SFPS_OP_SSE4) begin
      nkind = OP_SSE;
      ndur = 32'(SSE_CYC);
    end else begin
      nkind = OP_SE;
      ndur = 32'(SE_CYC);
    end
  end

  // ---------------------------------------------------------------
  // Operation engine
  // ---------------------------------------------------------------
  // runs on the core clock, no serial clock needed
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= ST_IDLE;
      rem_q <= 32'h0;
      lat_q <= 32'h0;
      kind_q <= OP_PP;
    end else begin
      case (st_q)
        ST_IDLE: begin
          if (start) begin
            st_q <= ST_RUN;
            rem_q <= ndur;
            kind_q <= nkind;
          end else if (res_pg) begin
            st_q <= ST_RUN;
            rem_q <= per_q;
            kind_q <= OP_PP;
          end else if (res_er) begin
            st_q <= ST_RUN;
            rem_q <= eer_q;
            kind_q <= erk_q;
          end
        end
        ST_RUN: begin
          rem_q <= rem_q - 32'h1;
          if (fin) begin
            st_q <= ST_IDLE;
          end else if (sus_cmd) begin
            st_q <= ST_SUSW;
            lat_q <= 32'(SUS_CYC);
          end
        end
        ST_SUSW: begin
          // work goes on during the latency and may finish first
          rem_q <= rem_q - 32'h1;
          lat_q <= lat_q - 32'h1;
          if (fin || sus_done) begin
            st_q <= ST_IDLE;
          end
        end
        default: st_q <= ST_IDLE;
      endcase
    end
  end

  // Saved contexts; lost on reset since nothing here is kept
  // volatile suspend state
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      {pgv_q, erv_q} <= 2'h0;
      per_q <= 32'h0;
      eer_q <= 32'h0;
      erad_q <= 32'h0;
      erk_q <= OP_SSE;
    end else if (sus_done && kind_q == OP_PP) begin
      pgv_q <= 1'b1;
      per_q <= rem_q;
    end else if (sus_done) begin
      erv_q <= 1'b1;
      eer_q <= rem_q;
      erk_q <= kind_q;
      erad_q <= ARR_ADDR;
    end else if (res_pg) begin
      pgv_q <= 1'b0;
    end else if (res_er) begin
      erv_q <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Status flags
  // ---------------------------------------------------------------
  // Clears come first so a same-cycle set wins
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      fsr_q <= `SFPS_FSR_RST;
    end else begin
      if (clf) begin
        fsr_q[`SFPS_FSR_EERR] <= 1'b0;
        fsr_q[`SFPS_FSR_PERR] <= 1'b0;
        fsr_q[`SFPS_FSR_PROT] <= 1'b0;
      end
      if (start || res_pg || res_er) begin
        fsr_q[`SFPS_FSR_RDY] <= 1'b0;
      end
      // ready high once suspended or done
      if (fin || sus_done) begin
        fsr_q[`SFPS_FSR_RDY] <= 1'b1;
      end
      if (res_pg || (fin && st_q == ST_SUSW && kind_q == OP_PP)) begin
        fsr_q[`SFPS_FSR_PSUS] <= 1'b0;
      end
      if (res_er || (fin && st_q == ST_SUSW && kind_q != OP_PP)) begin
        fsr_q[`SFPS_FSR_ESUS] <= 1'b0;
      end
      if (sus_cmd) begin
        fsr_q[kind_q == OP_PP ? `SFPS_FSR_PSUS : `SFPS_FSR_ESUS] <= 1'b1;
      end
      if (prg_ok && locked) begin
        fsr_q[`SFPS_FSR_PROT] <= 1'b1;
      end
      if (prg_ok && (locked || shit)) begin
        fsr_q[`SFPS_FSR_PERR] <= 1'b1;
      end
      if (er_lock) begin
        fsr_q[`SFPS_FSR_PROT] <= 1'b1;
        fsr_q[`SFPS_FSR_EERR] <= 1'b1;
      end
      if (fin && OP_FAIL) begin
        fsr_q[kind_q == OP_PP ? `SFPS_FSR_PERR : `SFPS_FSR_EERR] <= 1'b1;
      end
    end
  end

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      SR_WIP <= 1'b0;
    end else if (start || res_pg || res_er) begin
      SR_WIP <= 1'b1;
    end else if (fin || sus_done) begin
      SR_WIP <= 1'b0;
    end
  end

  // end of operation drops the latch; write enable wins a tie
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      wel_q <= 1'b0;
    end else if (go && op_q == `SFPS_OP_WREN) begin
      wel_q <= 1'b1;
    end else if (fin || (go && op_q == `SFPS_OP_WRDI)) begin
      wel_q <= 1'b0;
    end
  end

  // strap taken after reset release, then the mode commands
  logic [1:0] ldc_q;
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      ldc_q <= 2'h0;
      a4_q <= 1'b0;
    end else if (ldc_q != 2'h3) begin
      ldc_q <= ldc_q + 2'h1;
      a4_q <= nv2_q;
    end else if (go && op_q == `SFPS_OP_EN4) begin
      a4_q <= 1'b1;
    end else if (go && op_q == `SFPS_OP_EX4) begin
      a4_q <= 1'b0;
    end
  end

  // Frame bookkeeping so a frame with no clocks never replays an old command
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      frl_q <= 1'b0;
    end else if (cs2_q && !cs3_q) begin
      frl_q <= fr_q;
    end
  end

  // ---------------------------------------------------------------
  // Array side outputs
  // ---------------------------------------------------------------
  // erase target handed to the array with the area address
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      ARR_GO <= 1'b0;
      ARR_OP <= OP_PP;
      ARR_ADDR <= 32'h0;
      PB_LOAD <= 1'b0;
      PB_OFFSET <= 8'h0;
      PB_DATA <= 8'h0;
    end else begin
      ARR_GO <= start;
      PB_LOAD <= pt2_q ^ pt3_q;
      if (pt2_q ^ pt3_q) begin
        PB_OFFSET <= pbo_q;
        PB_DATA <= pbd_q;
      end
      if (start) begin
        ARR_OP <= nkind;
        ARR_ADDR <= addr;
      end else if (res_er) begin
        ARR_OP <= erk_q;
        ARR_ADDR <= erad_q;
      end
    end
  end

  assign FSR = fsr_q;
  assign SR_WEL = wel_q;
  assign ADDR4 = a4_q;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!rst_n);

  property p_busy_flags;
    (st_q == ST_RUN) |-> (SR_WIP && !FSR[`SFPS_FSR_RDY]);
  endproperty
  a_busy_flags: assert property (p_busy_flags) else $error("busy flags wrong");
  property p_fin_wel;
    (fin && !(go && op_q == `SFPS_OP_WREN)) |=> !SR_WEL && FSR[`SFPS_FSR_RDY];
  endproperty
  a_fin_wel: assert property (p_fin_wel) else $error("latch kept after end");
  property p_er_prot;
    er_lock |=> FSR[`SFPS_FSR_PROT] && FSR[`SFPS_FSR_EERR] && SR_WEL && st_q == ST_IDLE;
  endproperty
  a_er_prot: assert property (p_er_prot) else $error("protected erase mishandled");
  property p_pg_prot;
    (prg_ok && locked) |=> FSR[`SFPS_FSR_PROT] && FSR[`SFPS_FSR_PERR] && SR_WEL;
  endproperty
  a_pg_prot: assert property (p_pg_prot) else $error("protected program mishandled");
  property p_no_wel;
    (go && is_er && !wel_q && !busy) |=> st_q == ST_IDLE && $stable(fsr_q);
  endproperty
  a_no_wel: assert property (p_no_wel) else $error("erase ran without latch");
  property p_ragged;
    // A running operation may end on its own in that cycle, so only idle is judged
    (end_ev && !ok_q && !busy) |=> $stable(wel_q) && $stable(st_q) && $stable(fsr_q[5:1]);
  endproperty
  a_ragged: assert property (p_ragged) else $error("ragged frame acted on");
  property p_sus_flag;
    (sus_cmd && kind_q != OP_PP) |=> FSR[`SFPS_FSR_ESUS] ##1 !FSR[`SFPS_FSR_RDY];
  endproperty
  a_sus_flag: assert property (p_sus_flag) else $error("erase suspend flag missing");
  property p_sus_ready;
    sus_done |=> FSR[`SFPS_FSR_RDY] && !SR_WIP && (pgv_q || erv_q);
  endproperty
  a_sus_ready: assert property (p_sus_ready) else $error("suspend not reported");
  property p_res_idle;
    (res_cmd && !pgv_q && !erv_q) |=> st_q == ST_IDLE && $stable(fsr_q);
  endproperty
  a_res_idle: assert property (p_res_idle) else $error("idle resume had effect");
  property p_pp_time;
    prg_start |=> st_q == ST_RUN && rem_q == 32'(PP_CYC);
  endproperty
  a_pp_time: assert property (p_pp_time) else $error("program time wrong");

  c_prog_done: cover property (kind_q == OP_PP && fin && !OP_FAIL);
  c_erase_susp: cover property (sus_done && kind_q != OP_PP);
  c_nested: cover property (pgv_q && erv_q);
  c_late_fin: cover property (st_q == ST_SUSW && fin);
endmodule // sfps_core

// ==== sfps_host.sv ====
`timescale 1ns/1ps
// ----------------------------------------
// Host controller model on the serial link
// ----------------------------------------
module sfps_host (
  output logic SCK,
  output logic CS_B,
  output logic [3:0] DQ_I
);
  // Link idle: clock still, deselected
  initial begin
    SCK = 1'b0;
    CS_B = 1'b1;
    DQ_I = 4'h5;
  end
  // one frame, opcode first, MSB first on lane 0
  // The odd start offset keeps link edges off the core clock edges
  task automatic frame(input logic [47:0] v, input int nbit);
    #1.3 CS_B = 1'b0;
    for (int i = 0; i < nbit; i++) begin
      DQ_I = {~DQ_I[3:1], v[47-i]}; // Unused lanes toggle, never a stale level
      #12 SCK = 1'b1;
      #24 SCK = 1'b0;
      #12;
    end
    CS_B = 1'b1;
    DQ_I = ~DQ_I; // Released lines must not hold the last bit
    #100;
  endtask
endmodule // sfps_host

// ==== sfps_core_test.sv ====
`timescale 1ns/1ps
// ----------------------------------------
// Self-checking bench with a flag model
// ----------------------------------------
module sfps_core_test;
  import sfps_pkg::*;
  logic CLK, RST_B, SCK, CS_B, NV_ADDR4, OP_FAIL, SR_WIP, SR_WEL, ADDR4, ARR_GO;
  logic [3:0] DQ_I;
  logic [1:0] PROTO;
  logic [15:0] LOCK_MAP;
  logic [7:0] FSR, m_fsr;
  logic [31:0] ARR_ADDR, a;
  sfps_op_t ARR_OP;
  logic m_wel, m_wip, m_a4;
  int n_fail, n_tests;
  logic [33:0] go_q[$];
  logic PB_LOAD;
  logic [7:0] PB_OFFSET, PB_DATA;
  logic [15:0] pb_q[$];
  sfps_host u_host (.SCK(SCK), .CS_B(CS_B), .DQ_I(DQ_I));
  // Short op times keep the run brief; sector erase stays long enough to suspend
  sfps_core #(.PP_CYC(50), .SSE_CYC(200), .SE_CYC(5000), .BE_CYC(400)) u_dut (
    .CLK(CLK), .RST_B(RST_B), .SCK(SCK), .CS_B(CS_B), .DQ_I(DQ_I), .PROTO(PROTO),
    .NV_ADDR4(NV_ADDR4), .LOCK_MAP(LOCK_MAP), .OP_FAIL(OP_FAIL), .FSR(FSR),
    .SR_WIP(SR_WIP), .SR_WEL(SR_WEL), .ADDR4(ADDR4), .PB_LOAD(PB_LOAD),
    .PB_OFFSET(PB_OFFSET), .PB_DATA(PB_DATA), .ARR_GO(ARR_GO), .ARR_OP(ARR_OP),
    .ARR_ADDR(ARR_ADDR));
  // Core clock
  initial begin
    CLK = 1'b0;
    forever #5 CLK = ~CLK;
  end
  // Record every array start
  always @(posedge CLK) if (ARR_GO === 1'b1) go_q.push_back({ARR_OP, ARR_ADDR});
  // Record every page-buffer byte
  always @(posedge CLK) if (PB_LOAD === 1'b1) pb_q.push_back({PB_OFFSET, PB_DATA});
  task automatic chk_pb(input logic [15:0] e, input int n);
    n_tests++;
    if (pb_q.size() != n || (n == 1 && pb_q[0] !== e)) begin
      n_fail++;
      $display("ERROR %0t wrong page buffer byte", $time);
    end
    pb_q = {};
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge CLK);
    #1;
  endtask
  task automatic fr(input logic [47:0] v, input int nbit);
    u_host.frame(v, nbit);
    wt(8);
  endtask
  task automatic chk;
    n_tests++;
    if (FSR !== m_fsr || SR_WEL !== m_wel || SR_WIP !== m_wip || ADDR4 !== m_a4) begin
      n_fail++;
      $display("ERROR %0t flags %h %b %b %b", $time, FSR, SR_WEL, SR_WIP, ADDR4);
    end
  endtask
  task automatic chk_go(input logic [33:0] e, input int n);
    n_tests++;
    if (go_q.size() != n || (n == 1 && go_q[0] !== e)) begin
      n_fail++;
      $display("ERROR %0t wrong array start", $time);
    end
    go_q = {};
  endtask
  task automatic give_verdict;
    if (n_fail == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // Watchdog, well beyond the expected 100 us
  initial begin
    #500us;
    n_fail++;
    give_verdict();
  end
  // Main sequence
  initial begin
    RST_B = 1'b0;
    NV_ADDR4 = 1'b0;
    OP_FAIL = 1'b0;
    PROTO = 2'h0;
    a = $urandom(32'h84b8);
    // Regions 0 and 3 open for the erases below, 15 locked
    LOCK_MAP = 16'h8000 | (16'($urandom()) & 16'h7ff6);
    {m_fsr, m_wel, m_wip, m_a4} = {8'h80, 3'h0};
    repeat (10) @(posedge CLK);
    #1 RST_B = 1'b1;
    wt(10);
    chk();
    a = {10'h0, 22'($urandom())};
    fr({8'h20, a[23:0], 16'h0}, 32);
    chk_go(34'h0, 0);
    fr({8'h06, 40'h0}, 8);
    m_wel = 1'b1;
    fr({8'h12, a, 8'h5a}, 45);
    chk_go(34'h0, 0);
    chk_pb(16'h0, 0);
    chk();
    a[31:26] = 6'($urandom());
    fr({8'h12, a, 8'h5a}, 48);
    {m_fsr, m_wip} = {8'h00, 1'b1};
    chk_go({OP_PP, a}, 1);
    chk_pb({a[7:0], 8'h5a}, 1);
    wt(60);
    {m_fsr, m_wip, m_wel} = {8'h80, 2'h0};
    chk();
    fr({8'h06, 40'h0}, 8);
    fr({8'hb7, 40'h0}, 8);
    {m_wel, m_a4} = 2'h3;
    a[25:22] = 4'hf;
    fr({8'hd8, a, 8'h0}, 40);
    m_fsr = 8'ha2;
    chk();
    fr({8'h50, 40'h0}, 8);
    m_fsr = 8'h80;
    chk();
    fr({8'hc7, 40'h0}, 8);
    m_fsr = 8'ha2;
    chk();
    fr({8'h50, 40'h0}, 8);
    fr({8'he9, 40'h0}, 8);
    {m_fsr, m_a4} = {8'h80, 1'b0};
    fr({8'h20, a[23:0], 16'h0}, 32);
    {m_fsr, m_wip} = {8'h00, 1'b1};
    chk();
    OP_FAIL = 1'b1;
    wt(1);
    OP_FAIL = 1'b0;
    wt(4);
    {m_fsr, m_wip, m_wel} = {8'ha0, 2'h0};
    chk();
    fr({8'h50, 40'h0}, 8);
    fr({8'h06, 40'h0}, 8);
    fr({8'hd8, a[23:0], 16'h0}, 32);
    {m_fsr, m_wip, m_wel} = {8'h00, 2'h3};
    chk();
    fr({8'h75, 40'h0}, 8);
    m_fsr = 8'h40;
    chk();
    wt(3100);
    {m_fsr, m_wip} = {8'hc0, 1'b0};
    chk();
    fr({8'h7a, 40'h0}, 8);
    {m_fsr, m_wip} = {8'h00, 1'b1};
    chk();
    wt(5100);
    {m_fsr, m_wip, m_wel} = {8'h80, 2'h0};
    chk();
    fr({8'h7a, 40'h0}, 8);
    chk();
    give_verdict();
  end
endmodule // sfps_core_test
